//--- hdl/mnc_consts.vh
/*
  constants for the main oscillator configuration and tuning-word update bank:
  register offsets, field positions, reset values.
  assumes inclusion by bare name from the design files.
*/
`ifndef MNC_CONSTS_VH
`define MNC_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (byte-wide register port)
// ----------------------------------------------------------------
`define MNC_ADDR_PAGE 12'h008
`define MNC_ADDR_INTERP 12'h111
`define MNC_ADDR_CFG 12'h112
`define MNC_ADDR_UPD 12'h113
`define MNC_ADDR_TW0 12'h114
`define MNC_ADDR_TW5 12'h119

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MNC_CFG_MODE_HI 5
`define MNC_CFG_MODE_LO 4
`define MNC_CFG_NCO_EN 3
`define MNC_CFG_FRAC_EN 2
`define MNC_CFG_SIDEBAND 1
`define MNC_CFG_FOLLOW 0
`define MNC_UPD_MODE_HI 6
`define MNC_UPD_MODE_LO 4
`define MNC_UPD_ACK 1
`define MNC_UPD_REQ 0

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define MNC_CFG_RESET 8'h01
`define MNC_UPD_RESET 8'h00
`define MNC_INTERP_RESET 8'h04
`define MNC_CFG_WMASK 8'h3F
`define MNC_UPD_WMASK 8'h71
`define MNC_PAGE_WMASK 8'h03

`endif

//--- hdl/mnc_main_nco_config_update.v
/*
  main datapath oscillator configuration and tuning-word update register bank.
  assumes a byte-wide register port in clk_i domain; oscillator arithmetic lives outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mnc_consts.vh"

module mnc_main_nco_config_update #(
  parameter NUM_PATHS = 2,
  parameter DW = 16
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // register port
  input wire wr_i,
  input wire rd_i,
  input wire [11:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // oscillator handshake
  input wire [NUM_PATHS-1:0] load_done_i,
  output reg [NUM_PATHS-1:0] load_request_o,
  output reg [NUM_PATHS*48-1:0] main_tuning_word_o,
  output reg [NUM_PATHS-1:0] main_oscillator_enable_o,
  output reg [NUM_PATHS-1:0] fractional_dds_enable_o,
  output reg [NUM_PATHS-1:0] sideband_select_o,
  output reg [NUM_PATHS-1:0] channel_osc_follow_main_o,
  output reg [3:0] channel_interp_rate_o,
  // modulator switch, path 0 and path 1 sample streams
  input wire signed [DW-1:0] i0_i,
  input wire signed [DW-1:0] q0_i,
  input wire signed [DW-1:0] i1_i,
  input wire signed [DW-1:0] q1_i,
  output reg signed [DW:0] converter_out_0_o,
  output reg signed [DW:0] converter_out_1_o
);

  reg [7:0] page_q;
  reg [7:0] interp_q;
  wire [NUM_PATHS*8-1:0] cfg_w;
  wire [NUM_PATHS*8-1:0] upd_w;
  wire [NUM_PATHS*48-1:0] word_w;
  wire [NUM_PATHS-1:0] load_w;
  reg [7:0] rd_d;
  reg [DW:0] out0_d;
  reg [DW:0] out1_d;
  integer k;
  integer j;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one guard bit keeps the sum of two full-scale samples from wrapping
  function [DW:0] sext;
    input [DW-1:0] s;
    begin
      sext = {s[DW-1], s};
    end
  endfunction

  // byte number inside the 48-bit word, worked at three bits so that
  // bytes 4 and 5 (low address bits 0 and 1) wrap round to 4 and 5
  function [2:0] tw_byte;
    input [11:0] a;
    begin
      tw_byte = a[2:0] - 3'h4;
    end
  endfunction

  // true for any of the six tuning-word byte addresses
  function is_tw_addr;
    input [11:0] a;
    begin
      is_tw_addr = (a >= `MNC_ADDR_TW0) && (a <= `MNC_ADDR_TW5);
    end
  endfunction

  // one config bit of one path, taken from the flattened copies
  function cfg_bit;
    input [NUM_PATHS*8-1:0] v;
    input integer p;
    input integer b;
    begin
      cfg_bit = v[p*8 + b];
    end
  endfunction

  // ------------------------------------------------------------
  // per-path copies
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PATHS; g = g + 1) begin : g_path
      mnc_page_regs u_regs (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_i(wr_i && page_q[g]),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .load_done_i(load_done_i[g]),
        .cfg_o(cfg_w[g*8 +: 8]),
        .upd_o(upd_w[g*8 +: 8]),
        .word_o(word_w[g*48 +: 48]),
        .load_o(load_w[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // read mux: lowest selected page answers
  // ------------------------------------------------------------
  always @* begin
    rd_d = 8'h00;
    for (k = NUM_PATHS - 1; k >= 0; k = k - 1) begin
      if (page_q[k]) begin
        case (addr_i)
          `MNC_ADDR_CFG: rd_d = cfg_w[k*8 +: 8];
          `MNC_ADDR_UPD: rd_d = upd_w[k*8 +: 8];
          default: ;
        endcase
        if (is_tw_addr(addr_i))
          rd_d = word_w[k*48 + tw_byte(addr_i)*8 +: 8];
      end
    end
    if (addr_i == `MNC_ADDR_PAGE)
      rd_d = page_q;
    if (addr_i == `MNC_ADDR_INTERP)
      rd_d = interp_q;
  end

  // ------------------------------------------------------------
  // modulator switch, using path 0 mode
  // ------------------------------------------------------------
  always @* begin
    case (cfg_w[`MNC_CFG_MODE_HI:`MNC_CFG_MODE_LO])
      2'h0: begin
        out0_d = sext(i0_i);
        out1_d = sext(i1_i);
      end
      2'h1: begin
        out0_d = sext(i0_i) + sext(i1_i);
        out1_d = sext(q0_i) + sext(q1_i);
      end
      2'h2: begin
        out0_d = sext(i0_i);
        out1_d = sext(q0_i);
      end
      default: begin
        out0_d = sext(i0_i) + sext(i1_i);
        out1_d = {(DW+1){1'b0}};
      end
    endcase
  end

  // ------------------------------------------------------------
  // shared registers and read data
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      page_q <= 8'h01;
      interp_q <= `MNC_INTERP_RESET;
      rdata_o <= 8'h00;
    end else begin
      if (wr_i && addr_i == `MNC_ADDR_PAGE)
        page_q <= wdata_i & `MNC_PAGE_WMASK;
      // upper nibble belongs to the main interpolation rate, kept as storage only
      if (wr_i && addr_i == `MNC_ADDR_INTERP)
        interp_q <= wdata_i;
      // read data holds between reads so a slow host may pick it up late
      if (rd_i)
        rdata_o <= rd_d;
    end
  end

  // ------------------------------------------------------------
  // per-path outputs and the shared interpolation rate
  // ------------------------------------------------------------
  // re-registering costs one cycle after a write but keeps the pins glitch-free
  always @(posedge clk_i) begin
    if (reset_i) begin
      load_request_o <= {NUM_PATHS{1'b0}};
      main_tuning_word_o <= {(NUM_PATHS*48){1'b0}};
      main_oscillator_enable_o <= {NUM_PATHS{1'b0}};
      fractional_dds_enable_o <= {NUM_PATHS{1'b0}};
      sideband_select_o <= {NUM_PATHS{1'b0}};
      channel_osc_follow_main_o <= {NUM_PATHS{1'b1}};
      channel_interp_rate_o <= 4'h4;
    end else begin
      load_request_o <= load_w;
      main_tuning_word_o <= word_w;
      for (j = 0; j < NUM_PATHS; j = j + 1) begin
        main_oscillator_enable_o[j] <= cfg_bit(cfg_w, j, `MNC_CFG_NCO_EN);
        fractional_dds_enable_o[j] <= cfg_bit(cfg_w, j, `MNC_CFG_FRAC_EN);
        sideband_select_o[j] <= cfg_bit(cfg_w, j, `MNC_CFG_SIDEBAND);
        channel_osc_follow_main_o[j] <= cfg_bit(cfg_w, j, `MNC_CFG_FOLLOW);
      end
      channel_interp_rate_o <= interp_q[3:0];
    end
  end

  // ------------------------------------------------------------
  // modulator switch outputs
  // ------------------------------------------------------------
  // only path 0 steers the switch; path 1 mode bits are stored but unused
  always @(posedge clk_i) begin
    if (reset_i) begin
      converter_out_0_o <= {(DW+1){1'b0}};
      converter_out_1_o <= {(DW+1){1'b0}};
    end else begin
      converter_out_0_o <= out0_d;
      converter_out_1_o <= out1_d;
    end
  end

endmodule // mnc_main_nco_config_update
`default_nettype wire

//--- hdl/mnc_page_regs.v
/*
  one datapath's copy of the configuration and update registers, with the
  tuning-word bytes and load request edge detection.
  assumes a single-cycle write strobe from the register port on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mnc_consts.vh"

module mnc_page_regs (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // write port, already qualified by page select
  input wire wr_i,
  input wire [11:0] addr_i,
  input wire [7:0] wdata_i,
  // load acknowledge from the oscillator
  input wire load_done_i,
  // register contents
  output reg [7:0] cfg_o,
  output reg [7:0] upd_o,
  output reg [47:0] word_o,
  output reg load_o
);

  reg [7:0] upd_d;
  reg tw_wr;
  reg [2:0] tw_idx;
  reg auto_req;
  reg req_rise;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always @* begin
    tw_wr = wr_i && addr_i >= `MNC_ADDR_TW0 && addr_i <= `MNC_ADDR_TW5;
    tw_idx = addr_i[2:0] - 3'h4;
    // byte n write pairs with mode code n+1
    auto_req = tw_wr && upd_o[`MNC_UPD_MODE_HI:`MNC_UPD_MODE_LO] != 3'h0 &&
      upd_o[`MNC_UPD_MODE_HI:`MNC_UPD_MODE_LO] == tw_idx + 3'h1;
    upd_d = upd_o;
    if (wr_i && addr_i == `MNC_ADDR_UPD) begin
      upd_d = (wdata_i & `MNC_UPD_WMASK) | (upd_o & 8'h02);
      if (!wdata_i[`MNC_UPD_REQ])
        upd_d[`MNC_UPD_ACK] = 1'b0;
    end
    // completion wins over a same-cycle clear
    if (load_done_i)
      upd_d[`MNC_UPD_ACK] = 1'b1;
    req_rise = wr_i && addr_i == `MNC_ADDR_UPD && wdata_i[`MNC_UPD_REQ] &&
      !upd_o[`MNC_UPD_REQ];
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      cfg_o <= `MNC_CFG_RESET;
      upd_o <= `MNC_UPD_RESET;
      word_o <= 48'h000000000000;
      load_o <= 1'b0;
    end else begin
      if (wr_i && addr_i == `MNC_ADDR_CFG)
        cfg_o <= wdata_i & `MNC_CFG_WMASK;
      upd_o <= upd_d;
      if (tw_wr)
        word_o[tw_idx*8 +: 8] <= wdata_i;
      load_o <= req_rise | auto_req;
    end
  end

endmodule // mnc_page_regs
`default_nettype wire

//--- tb/mnc_chk.sv
/* checker for the oscillator configuration bank, watching path 0 and the register port.
   assumes the bank's top-level ports and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module mnc_chk #(parameter NUM_PATHS = 2) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  // watched outputs
  input wire logic [NUM_PATHS-1:0] load_request_o,
  input wire logic [NUM_PATHS-1:0] main_oscillator_enable_o,
  input wire logic [NUM_PATHS-1:0] sideband_select_o,
  input wire logic [NUM_PATHS-1:0] channel_osc_follow_main_o,
  input wire logic [3:0] channel_interp_rate_o
);
  logic [1:0] pg_q;
  logic req_q;
  logic [2:0] mode_q;
  // shadow of path 0 state, needed because the edge is taken from the stored bit
  always @(posedge clk_i) begin
    if (reset_i) begin
      pg_q <= 2'h1;
      req_q <= 1'b0;
      mode_q <= 3'h0;
    end else if (wr_i && addr_i == 12'h008) begin
      pg_q <= wdata_i[1:0];
    end else if (wr_i && addr_i == 12'h113 && pg_q[0]) begin
      req_q <= wdata_i[0];
      mode_q <= wdata_i[6:4];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_req_rise;
    wr_i && addr_i == 12'h113 && pg_q[0] && wdata_i[0] && !req_q;
  endsequence
  sequence s_auto;
    wr_i && pg_q[0] && mode_q != 3'h0 && addr_i == 12'h113 + {9'h000, mode_q};
  endsequence
  property p_req; s_req_rise |-> ##2 load_request_o[0]; endproperty
  a_req: assert property (p_req) else $error("request edge gave no load pulse");
  property p_auto; s_auto |-> ##2 load_request_o[0]; endproperty
  a_auto: assert property (p_auto) else $error("auto mode gave no load pulse");
  property p_pulse; load_request_o[0] |=> !load_request_o[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("load pulse too long");
  property p_cause;
    $rose(load_request_o[0]) |-> $past(wr_i && addr_i >= 12'h113 && addr_i <= 12'h119, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("load pulse without write");
  property p_en; !$stable(main_oscillator_enable_o) |-> $past(wr_i && addr_i == 12'h112, 2);
  endproperty
  a_en: assert property (p_en) else $error("enable moved without write");
  property p_sb; !$stable(sideband_select_o) |-> $past(wr_i && addr_i == 12'h112, 2);
  endproperty
  a_sb: assert property (p_sb) else $error("sideband moved without write");
  property p_fol; !$stable(channel_osc_follow_main_o) |-> $past(wr_i && addr_i == 12'h112, 2);
  endproperty
  a_fol: assert property (p_fol) else $error("follow moved without write");
  property p_ir; !$stable(channel_interp_rate_o) |-> $past(wr_i && addr_i == 12'h111, 2);
  endproperty
  a_ir: assert property (p_ir) else $error("interp moved without write");
  property p_unm; (rd_i && addr_i == 12'h200) ##1 !rd_i |-> ##1 rdata_o == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // mnc_chk
bind mnc_main_nco_config_update mnc_chk #(.NUM_PATHS(NUM_PATHS)) mnc_chk_i (.clk_i, .reset_i,
  .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .load_request_o, .main_oscillator_enable_o,
  .sideband_select_o, .channel_osc_follow_main_o, .channel_interp_rate_o);
`default_nettype wire

//--- tb/tb_top.sv
/* self-checking bench for the oscillator configuration bank.
   assumes default parameters, 250 MHz clock, inputs driven on the falling edge. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_i, reset_i, wr_i, rd_i;
  logic [11:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [7:0] cf [2];
  logic [1:0] load_done_i, load_request_o, en_o, fr_o, sb_o, fol_o;
  logic [95:0] tw_o;
  logic [47:0] tw;
  logic [3:0] ir_o;
  logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
  logic signed [15:0] i0, q0, i1, q1;
  logic signed [16:0] c0_o, c1_o;
  logic [15:0] lf_q;
  int n_mismatch, n_checks, n_req, cyc;
  mnc_main_nco_config_update #(.NUM_PATHS(2), .DW(16)) mnc_main_nco_config_update_i (
    .clk_i(clk_i), .reset_i(reset_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .load_done_i(load_done_i),
    .load_request_o(load_request_o), .main_tuning_word_o(tw_o), .main_oscillator_enable_o(en_o),
    .fractional_dds_enable_o(fr_o), .sideband_select_o(sb_o), .channel_osc_follow_main_o(fol_o),
    .channel_interp_rate_o(ir_o), .i0_i(i0), .q0_i(q0), .i1_i(i1), .q1_i(q1),
    .converter_out_0_o(c0_o), .converter_out_1_o(c1_o));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [33:0] modsw(input logic [1:0] m);
    logic [16:0] s, t;
    s = {i0[15], i0} + {i1[15], i1};
    t = {q0[15], q0} + {q1[15], q1};
    case (m)
      2'h0: return {i0[15], i0, i1[15], i1};
      2'h1: return {s, t};
      2'h2: return {i0[15], i0, q0[15], q0};
      default: return {s, 17'h00000};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_i, addr_i, wdata_i} = {1'b1, a, d};
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_i);
    {rd_i, addr_i} = {1'b1, a};
    @(negedge clk_i);
    rd_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(nm, {40'h0, e}, {40'h0, rdata_o});
  endtask
  // requests are counted by the monitor, so a double pulse is seen too
  task automatic pulses(input int e);
    repeat (6) @(negedge clk_i);
    chk("load requests", e, n_req);
    n_req = 0;
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    n_req += load_request_o[0] + load_request_o[1];
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    {reset_i, wr_i, rd_i, addr_i, wdata_i, load_done_i} = {1'b1, 24'h000000};
    {i0, q0, i1, q1} = 64'h0;
    lf_q = 16'h0034;
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    rd_chk("cfg reset", 12'h112, 8'h01);
    rd_chk("upd reset", 12'h113, 8'h00);
    rd_chk("interp reset", 12'h111, 8'h04);
    rd_chk("unmapped", 12'h200, 8'h00);
    chk("cfg outs reset", 48'h3, {en_o, fr_o, sb_o, fol_o});
    for (int p = 0; p < 4; p++) begin
      lf_q = lfsr(lf_q);
      cf[p[0]] = (p == 3) ? 8'hFF : lf_q[7:0];
      wr(12'h008, 8'h01 << p[0]);
      wr(12'h112, cf[p[0]]);
    end
    for (int p = 0; p < 2; p++) begin
      wr(12'h008, 8'h01 << p);
      rd_chk("cfg page", 12'h112, cf[p] & 8'h3F);
      chk("cfg outs", cf[p][3:0], {en_o[p], fr_o[p], sb_o[p], fol_o[p]});
    end
    wr(12'h008, 8'h01);
    for (int m = 0; m < 4; m++) begin
      lf_q = lfsr(lf_q);
      {i0, q0, i1, q1} = {lf_q, ~lf_q, lf_q ^ 16'h8001, lf_q[7:0], lf_q[15:8]};
      wr(12'h112, {2'h0, m[1:0], 4'h8});
      repeat (4) @(negedge clk_i);
      chk("converter outs", modsw(m[1:0]), {c0_o, c1_o});
    end
    foreach (codes[k]) begin
      wr(12'h111, {4'h8, codes[k]});
      repeat (3) @(negedge clk_i);
      chk("interp rate", codes[k], ir_o);
    end
    n_req = 0;
    for (int m = 0; m < 7; m++) begin
      lf_q = lfsr(lf_q);
      wr(12'h113, {1'b0, m[2:0], 4'h0});
      wr(12'h114 + (m == 0 ? 12'h000 : m[11:0] - 12'h001), lf_q[7:0]);
      tw[8 * (m == 0 ? 0 : m - 1) +: 8] = lf_q[7:0];
      pulses(m != 0);
    end
    chk("tuning word", tw, tw_o[47:0]);
    chk("other path word", 48'h0, tw_o[95:48]);
    wr(12'h113, 8'h01);
    pulses(1);
    wr(12'h113, 8'h01);
    pulses(0);
    load_done_i = 2'b01;
    @(negedge clk_i);
    load_done_i = 2'b00;
    rd_chk("ack set", 12'h113, 8'h03);
    wr(12'h113, 8'h8C);
    rd_chk("ack cleared", 12'h113, 8'h00);
    wr(12'h008, 8'h03);
    rd_chk("page both", 12'h008, 8'h03);
    rd_chk("lowest page cfg", 12'h112, 8'h38);
    wr(12'h112, 8'h08);
    repeat (2) @(negedge clk_i);
    chk("both enabled", 2'h3, en_o);
    for (int b = 0; b < 6; b++)
      wr(12'h114 + b[11:0], 8'h00);
    repeat (2) @(negedge clk_i);
    chk("zero word 0", 48'h0, tw_o[47:0]);
    chk("zero word 1", 48'h0, tw_o[95:48]);
    n_req = 0;
    wr(12'h113, 8'h01);
    pulses(2);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
